/* File: hdl/adcc_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
// Function
// - reference select bit: 0 routes bandgap, 1 routes external reference
// - manual mode converts only the channel named by the channel select
// - group mode converts four channels, group picked by top select bit
// - writing the single-run trigger starts one immediate pass
// - clearing converter power-up powers the converter down
// - writing the interrupt-clear bit clears the pending flag
// - interrupt leaves the block only while interrupt enable is one
// - repeat bit makes passes run continuously
// - clearing reference power-up powers down the bandgap
// - status bit 0 shows the done flag, set at pass end (after the fourth conversion in group mode)
// - correction order bit: 0 first order, 1 second order
// - group mode uses dedicated inputs or upper inputs, low select bits ignored
// - each input buffer bit powers its buffer down when low
// - four 12-bit results, low byte holds the eight low bits
// - high byte holds result bits 11..8 in bits 3..0, rest zero
// - calibration skip bit bypasses the automatic calibration phase
// - four-bit field addresses the calibration table
// - three rate registers form a 24-bit repeat interval
// - eight-bit divisor derives the converter clock from the system clock
module adcc_ctrl
   import adcc_pkg::*;
(
   // clock and reset
   input  wire logic             SYS_CLK,
   input  wire logic             RST_B,
   // register port
   input  wire logic [7:0]       SFR_ADDR,
   input  wire logic             SFR_WR,
   input  wire logic [7:0]       SFR_WDATA,
   output var  logic [7:0]       SFR_RDATA,
   // converter core handshake
   input  wire logic             CONV_DONE,
   input  wire logic [RES_W-1:0] CONV_DATA,
   output var  logic             CONV_START,
   output var  logic [2:0]       MUX_CH,
   output var  logic             CONV_CLK,
   // analog controls
   output var  logic             REFERENCE_SELECT,
   output var  logic             CONVERTER_POWERUP,
   output var  logic             REFERENCE_POWERUP,
   output var  logic [3:0]       INPUT_BUFFER_POWERUP,
   output var  logic             REFERENCE_CORRECTION_ORDER,
   output var  logic             SKIP_AUTOCAL,
   output var  logic [3:0]       CAL_TABLE_INDEX,
   output var  logic [7:0]       REFERENCE_TRIM_DATA,
   // interrupt
   output var  logic             IRQ
);

   // =====================================================================
   // state
   logic [7:0]       ctrl_ff;
   logic [7:0]       trim_ff;
   logic [7:0]       cal_ff;
   logic [7:0]       muxc_ff;
   logic [7:0]       rate_lo_ff;
   logic [7:0]       rate_md_ff;
   logic [7:0]       rate_hi_ff;
   logic [7:0]       div_ff;
   logic [RES_W-1:0] res_ff [NUM_CH];
   logic             flag_ff;
   logic [1:0]       idx_ff;
   logic [1:0]       slot_ff;
   logic             done_s1_ff;
   logic             done_s2_ff;
   logic             done_s3_ff;
   logic             done_lvl_ff;
   adcc_seq_t        state_ff;
   adcc_seq_t        nxt_state;
   logic [1:0]       nxt_idx;
   logic [7:0]       nxt_rdata;
   logic             gap_done;

   // =====================================================================
   // decode
   wire logic       wr_ctrl    = SFR_WR && (SFR_ADDR == ADDR_CTRL);
   wire logic       single_req = wr_ctrl && SFR_WDATA[CTL_SINGLE_BIT];
   wire logic       irq_clr    = wr_ctrl && SFR_WDATA[CTL_IRQ_CLR_BIT];
   wire logic       pwr        = ctrl_ff[CTL_PWR_BIT];
   wire logic       manual     = ctrl_ff[CTL_MANUAL_BIT];
   wire logic       repeat_on  = ctrl_ff[CTL_REPEAT_BIT];
   wire logic [2:0] sel        = muxc_ff[MUX_SEL_LSB +: 3];
   // group mode keeps only the top select bit
   wire logic [2:0] cur_chan   = manual ? sel : {sel[2], idx_ff};
   wire logic [1:0] cur_slot   = manual ? sel[1:0] : idx_ff;
   // edge judged from agreeing second and third stages against the last stable level
   wire logic       done_rise  = (done_s2_ff == done_s3_ff) && done_s3_ff && !done_lvl_ff;
   wire logic       last_conv  = manual || (idx_ff == 2'd3);
   wire logic       store      = pwr && (state_ff == SQ_WAIT) && done_rise;
   wire logic       pass_end   = store && last_conv;
   wire logic       gap_start  = pass_end && repeat_on;
   wire logic [RATE_W-1:0] rate_word = {rate_hi_ff, rate_md_ff, rate_lo_ff};

   function automatic logic [7:0] res_byte(input logic [RES_W-1:0] r, input logic hi);
      res_byte = hi ? {4'h0, r[RES_W-1:8]} : r[7:0];
   endfunction

   // =====================================================================
   // analog controls come straight from register bits
   assign REFERENCE_SELECT           = ctrl_ff[CTL_REF_SEL_BIT];
   assign CONVERTER_POWERUP          = ctrl_ff[CTL_PWR_BIT];
   assign REFERENCE_POWERUP          = ctrl_ff[CTL_REFPWR_BIT];
   assign INPUT_BUFFER_POWERUP       = muxc_ff[MUX_BUF_LSB +: 4];
   assign REFERENCE_CORRECTION_ORDER = muxc_ff[MUX_ORDER_BIT];
   assign SKIP_AUTOCAL               = cal_ff[CAL_SKIP_BIT];
   assign CAL_TABLE_INDEX            = cal_ff[CAL_IDX_LSB +: 4];
   assign REFERENCE_TRIM_DATA        = trim_ff;

   // =====================================================================
   // register writes
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         ctrl_ff    <= RST_CTRL;
         trim_ff    <= RST_TRIM;
         cal_ff     <= RST_CAL;
         muxc_ff    <= RST_MUX;
         rate_lo_ff <= RST_RATE;
         rate_md_ff <= RST_RATE;
         rate_hi_ff <= RST_RATE;
         div_ff     <= RST_DIV;
      end else if (SFR_WR) begin
         if (SFR_ADDR == ADDR_CTRL)    ctrl_ff    <= SFR_WDATA & CTRL_STORE_MASK;
         if (SFR_ADDR == ADDR_TRIM)    trim_ff    <= SFR_WDATA;
         if (SFR_ADDR == ADDR_CAL)     cal_ff     <= SFR_WDATA & CAL_STORE_MASK;
         if (SFR_ADDR == ADDR_MUX)     muxc_ff    <= SFR_WDATA;
         if (SFR_ADDR == ADDR_RATE_LO) rate_lo_ff <= SFR_WDATA;
         if (SFR_ADDR == ADDR_RATE_MD) rate_md_ff <= SFR_WDATA;
         if (SFR_ADDR == ADDR_RATE_HI) rate_hi_ff <= SFR_WDATA;
         if (SFR_ADDR == ADDR_DIV)     div_ff     <= SFR_WDATA;
      end
   end

   // =====================================================================
   // read data, one cycle after the address
   always_comb begin
      unique case (SFR_ADDR)
         ADDR_CTRL:    nxt_rdata = ctrl_ff;
         ADDR_TRIM:    nxt_rdata = trim_ff;
         ADDR_CAL:     nxt_rdata = cal_ff;
         ADDR_MUX:     nxt_rdata = muxc_ff;
         ADDR_RATE_LO: nxt_rdata = rate_lo_ff;
         ADDR_RATE_MD: nxt_rdata = rate_md_ff;
         ADDR_RATE_HI: nxt_rdata = rate_hi_ff;
         ADDR_DIV:     nxt_rdata = div_ff;
         ADDR_STATUS:  nxt_rdata = {7'h00, flag_ff};
         ADDR_RES0_LO: nxt_rdata = res_byte(res_ff[0], 1'b0);
         ADDR_RES0_HI: nxt_rdata = res_byte(res_ff[0], 1'b1);
         ADDR_RES1_LO: nxt_rdata = res_byte(res_ff[1], 1'b0);
         ADDR_RES1_HI: nxt_rdata = res_byte(res_ff[1], 1'b1);
         ADDR_RES2_LO: nxt_rdata = res_byte(res_ff[2], 1'b0);
         ADDR_RES2_HI: nxt_rdata = res_byte(res_ff[2], 1'b1);
         ADDR_RES3_LO: nxt_rdata = res_byte(res_ff[3], 1'b0);
         ADDR_RES3_HI: nxt_rdata = res_byte(res_ff[3], 1'b1);
         default:      nxt_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         SFR_RDATA <= 8'h00;
      end else begin
         SFR_RDATA <= nxt_rdata;
      end
   end

   // =====================================================================
   // done synchroniser; data is held steady by the core while done is high
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         done_s1_ff  <= 1'b0;
         done_s2_ff  <= 1'b0;
         done_s3_ff  <= 1'b0;
         done_lvl_ff <= 1'b0;
      end else begin
         done_s1_ff <= CONV_DONE;
         done_s2_ff <= done_s1_ff;
         done_s3_ff <= done_s2_ff;
         if (done_s2_ff == done_s3_ff) done_lvl_ff <= done_s3_ff;
      end
   end

   // =====================================================================
   // sequencer; a trigger during a conversion is dropped
   always_comb begin
      nxt_state = state_ff;
      nxt_idx   = idx_ff;
      if (!pwr) begin
         nxt_state = SQ_IDLE;
      end else begin
         unique case (state_ff)
            SQ_IDLE: begin
               if (single_req || repeat_on) begin
                  nxt_state = SQ_LAUNCH;
                  nxt_idx   = 2'd0;
               end
            end
            SQ_LAUNCH: nxt_state = SQ_WAIT;
            SQ_WAIT: begin
               if (done_rise) begin
                  if (last_conv) begin
                     nxt_state = repeat_on ? SQ_GAP : SQ_IDLE;
                  end else begin
                     nxt_state = SQ_LAUNCH;
                     nxt_idx   = idx_ff + 2'd1;
                  end
               end
            end
            SQ_GAP: begin
               if (single_req || gap_done) begin
                  nxt_state = SQ_LAUNCH;
                  nxt_idx   = 2'd0;
               end else if (!repeat_on) begin
                  nxt_state = SQ_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         state_ff   <= SQ_IDLE;
         idx_ff     <= 2'd0;
         slot_ff    <= 2'd0;
         MUX_CH     <= 3'h0;
         CONV_START <= 1'b0;
      end else begin
         state_ff   <= nxt_state;
         idx_ff     <= nxt_idx;
         CONV_START <= pwr && (state_ff == SQ_LAUNCH);
         if (state_ff == SQ_LAUNCH) begin
            MUX_CH  <= cur_chan;
            slot_ff <= cur_slot;
         end
      end
   end

   // =====================================================================
   // results; each stored on its done rise, the last of a pass in the same edge the done flag is set
   for (genvar g = 0; g < NUM_CH; g++) begin : g_res
      always_ff @(posedge SYS_CLK or negedge RST_B) begin
         if (!RST_B) begin
            res_ff[g] <= '0;
         end else if (store && (slot_ff == 2'(g))) begin
            res_ff[g] <= CONV_DATA;
         end
      end
   end

   // =====================================================================
   // done flag and interrupt; a new pass end beats a clear
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         flag_ff <= 1'b0;
         IRQ     <= 1'b0;
      end else begin
         flag_ff <= pass_end || (flag_ff && !irq_clr);
         IRQ     <= flag_ff && ctrl_ff[CTL_IRQ_EN_BIT];
      end
   end

   adcc_pacer u_pacer (
      .sys_clk   (SYS_CLK),
      .rst_b     (RST_B),
      .divisor   (div_ff),
      .rate_word (rate_word),
      .gap_start (gap_start),
      .gap_done  (gap_done),
      .conv_clk  (CONV_CLK)
   );

   // =====================================================================
   // checks
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RST_B);

   sequence s_launch;
      (state_ff == SQ_LAUNCH) ##1 CONV_START;
   endsequence

   property p_irq_gate;
      !ctrl_ff[CTL_IRQ_EN_BIT] |=> !IRQ;
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("irq without enable");

   property p_irq_clear;
      irq_clr && !pass_end |=> !flag_ff;
   endproperty
   a_irq_clear: assert property (p_irq_clear) else $error("flag not cleared");

   property p_flag_set;
      pass_end |=> flag_ff ##1 (flag_ff || $past(irq_clr));
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("flag not set at pass end");

   property p_flag_hold;
      flag_ff && !irq_clr |=> flag_ff;
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("flag dropped");

   property p_pwr_down;
      !pwr |=> (state_ff == SQ_IDLE) && !CONV_START;
   endproperty
   a_pwr_down: assert property (p_pwr_down) else $error("active while off");

   property p_single;
      single_req && pwr && (state_ff == SQ_IDLE) |=> s_launch;
   endproperty
   a_single: assert property (p_single) else $error("trigger not started");

   property p_manual_ch;
      CONV_START && $past(manual) |-> MUX_CH == $past(sel);
   endproperty
   a_manual_ch: assert property (p_manual_ch) else $error("wrong manual channel");

   property p_group_ch;
      CONV_START && !$past(manual) |-> MUX_CH == {$past(sel[2]), $past(idx_ff)};
   endproperty
   a_group_ch: assert property (p_group_ch) else $error("wrong group channel");

   property p_store;
      store && (slot_ff == 2'd0) |=> res_ff[0] == $past(CONV_DATA);
   endproperty
   a_store: assert property (p_store) else $error("result not stored");

   property p_repeat;
      pass_end && repeat_on |=> (state_ff == SQ_GAP) || !$past(pwr);
   endproperty
   a_repeat: assert property (p_repeat) else $error("repeat pass not paced");

endmodule
`default_nettype wire

/* File: shared/adcc_pkg.sv */
`default_nettype none
// =====================================================================
// converter control constants
package adcc_pkg;

   // =====================================================================
   // register offsets on the special-function-register port
   localparam logic [7:0] ADDR_CTRL    = 8'h94;
   localparam logic [7:0] ADDR_TRIM    = 8'h95;
   localparam logic [7:0] ADDR_CAL     = 8'h96;
   localparam logic [7:0] ADDR_RES0_LO = 8'hA4;
   localparam logic [7:0] ADDR_RES0_HI = 8'hA5;
   localparam logic [7:0] ADDR_RES1_LO = 8'hA6;
   localparam logic [7:0] ADDR_RES1_HI = 8'hA7;
   localparam logic [7:0] ADDR_RES2_LO = 8'hAC;
   localparam logic [7:0] ADDR_RES2_HI = 8'hAD;
   localparam logic [7:0] ADDR_RES3_LO = 8'hAE;
   localparam logic [7:0] ADDR_RES3_HI = 8'hAF;
   localparam logic [7:0] ADDR_STATUS  = 8'hBC;
   localparam logic [7:0] ADDR_RATE_LO = 8'hF5;
   localparam logic [7:0] ADDR_RATE_MD = 8'hF6;
   localparam logic [7:0] ADDR_RATE_HI = 8'hF7;
   localparam logic [7:0] ADDR_MUX     = 8'hFC;
   localparam logic [7:0] ADDR_DIV     = 8'hFE;

   // =====================================================================
   // field positions
   localparam int CTL_REF_SEL_BIT = 7;
   localparam int CTL_MANUAL_BIT  = 6;
   localparam int CTL_SINGLE_BIT  = 5;
   localparam int CTL_PWR_BIT     = 4;
   localparam int CTL_IRQ_CLR_BIT = 3;
   localparam int CTL_IRQ_EN_BIT  = 2;
   localparam int CTL_REPEAT_BIT  = 1;
   localparam int CTL_REFPWR_BIT  = 0;
   localparam int STS_DONE_BIT    = 0;
   localparam int MUX_ORDER_BIT   = 7;
   localparam int MUX_SEL_LSB     = 4;
   localparam int MUX_BUF_LSB     = 0;
   localparam int CAL_SKIP_BIT    = 4;
   localparam int CAL_IDX_LSB     = 0;

   // =====================================================================
   // widths and reset values
   localparam int         RES_W      = 12;
   localparam int         NUM_CH     = 4;
   localparam int         RATE_W     = 24;
   localparam logic [7:0] RST_CTRL   = 8'h00;
   localparam logic [7:0] RST_TRIM   = 8'h00;
   localparam logic [7:0] RST_CAL    = 8'h00;
   localparam logic [7:0] RST_MUX    = 8'h00;
   localparam logic [7:0] RST_RATE   = 8'h00;
   // trigger and clear bits are strobes and never stored
   localparam logic [7:0] CTRL_STORE_MASK = 8'hD7;
   localparam logic [7:0] CAL_STORE_MASK  = 8'h1F;

   // =====================================================================
   // timing: converter clock period is 2 * divisor system clocks
   localparam int         SYS_CLK_HZ         = 10_000_000;
   localparam int         CONV_CLK_TARGET_HZ = 250_000;
   localparam logic [7:0] RST_DIV = 8'(SYS_CLK_HZ / (2 * CONV_CLK_TARGET_HZ));

   typedef enum logic [1:0] {SQ_IDLE, SQ_LAUNCH, SQ_WAIT, SQ_GAP} adcc_seq_t;

endpackage
`default_nettype wire

/* File: hdl/adcc_pacer.sv */
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// converter clock divider and repeat-interval timer
module adcc_pacer
   import adcc_pkg::*;
(
   // clock and reset
   input  wire logic              sys_clk,
   input  wire logic              rst_b,
   // settings
   input  wire logic [7:0]        divisor,
   input  wire logic [RATE_W-1:0] rate_word,
   // interval handshake
   input  wire logic              gap_start,
   output var  logic              gap_done,
   // divided clock
   output var  logic              conv_clk
);

   logic [7:0]        div_cnt_ff;
   logic [RATE_W-1:0] gap_cnt_ff;
   logic              run_ff;

   // a zero divisor would stall the clock, so it acts as one
   wire logic [7:0] limit    = (divisor == 8'h00) ? 8'h01 : divisor;
   wire logic       half_end = (div_cnt_ff >= limit - 8'h01);
   wire logic       tick     = half_end && !conv_clk;
   wire logic       expired  = run_ff && (gap_cnt_ff >= rate_word);

   // =====================================================================
   // divider
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         div_cnt_ff <= 8'h00;
         conv_clk   <= 1'b0;
      end else if (half_end) begin
         div_cnt_ff <= 8'h00;
         conv_clk   <= !conv_clk;
      end else begin
         div_cnt_ff <= div_cnt_ff + 8'h01;
      end
   end

   // =====================================================================
   // interval counted in converter clock periods
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         gap_cnt_ff <= '0;
         run_ff     <= 1'b0;
         gap_done   <= 1'b0;
      end else if (gap_start) begin
         gap_cnt_ff <= '0;
         run_ff     <= 1'b1;
         gap_done   <= 1'b0;
      end else if (expired) begin
         run_ff     <= 1'b0;
         gap_done   <= 1'b1;
      end else begin
         gap_done   <= 1'b0;
         if (run_ff && tick) begin
            gap_cnt_ff <= gap_cnt_ff + 24'h000001;
         end
      end
   end

endmodule
`default_nettype wire

/* File: test/adcc_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// behavioural converter core: one result per start, queued in order
module adcc_core_model
   import adcc_pkg::*;
(
   // clock and reset
   input  wire logic                  SYS_CLK,
   input  wire logic                  RST_B,
   // start side
   input  wire logic                  CONV_START,
   input  wire logic [2:0]            MUX_CH,
   // per-channel sample values and response delay
   input  wire logic [8*RES_W-1:0]    VALUES,
   input  wire logic [3:0]            DELAY,
   // result side
   output var  logic                  CONV_DONE,
   output var  logic [RES_W-1:0]      CONV_DATA
);
   logic [2:0] start_q[$];
   logic [2:0] ch;

   always @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         start_q.delete();
      end else if (CONV_START) begin
         start_q.push_back(MUX_CH);
      end
   end

   // data is only held for the documented window, then scrambled
   initial begin
      CONV_DONE = 1'b0;
      CONV_DATA = 12'hA5A;
      forever begin
         @(negedge SYS_CLK);
         if (start_q.size() != 0) begin
            ch = start_q.pop_front();
            repeat (DELAY) @(negedge SYS_CLK);
            CONV_DATA = VALUES[ch*RES_W +: RES_W];
            CONV_DONE = 1'b1;
            repeat (4) @(negedge SYS_CLK);
            CONV_DONE = 1'b0;
            CONV_DATA = ~CONV_DATA;
         end
      end
   end
endmodule
`default_nettype wire

/* File: test/tb_adc_control_interface.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_adc_control_interface
   import adcc_pkg::*;
;
   logic sys_clk, rst_b, sfr_wr, conv_done, conv_start, conv_clk, irq;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, trim;
   logic [RES_W-1:0] conv_data;
   logic [2:0] mux_ch;
   logic ref_sel, cnv_pwr, ref_pwr, order, skip;
   logic [3:0] ibuf, cal_idx, dly;
   logic [8*RES_W-1:0] vals;
   int errors, checks;
   logic [7:0] d, m, c;
   int n, last, gap;

   // =====================================================================
   // clock, design and converter model
   initial sys_clk = 1'b0;
   always #50 sys_clk = ~sys_clk;

   adcc_ctrl dut (.SYS_CLK(sys_clk), .RST_B(rst_b), .SFR_ADDR(sfr_addr), .SFR_WR(sfr_wr),
      .SFR_WDATA(sfr_wdata), .SFR_RDATA(sfr_rdata), .CONV_DONE(conv_done),
      .CONV_DATA(conv_data), .CONV_START(conv_start), .MUX_CH(mux_ch), .CONV_CLK(conv_clk),
      .REFERENCE_SELECT(ref_sel), .CONVERTER_POWERUP(cnv_pwr), .REFERENCE_POWERUP(ref_pwr),
      .INPUT_BUFFER_POWERUP(ibuf), .REFERENCE_CORRECTION_ORDER(order),
      .SKIP_AUTOCAL(skip), .CAL_TABLE_INDEX(cal_idx), .REFERENCE_TRIM_DATA(trim), .IRQ(irq));

   adcc_core_model core (.SYS_CLK(sys_clk), .RST_B(rst_b), .CONV_START(conv_start),
      .MUX_CH(mux_ch), .VALUES(vals), .DELAY(dly), .CONV_DONE(conv_done),
      .CONV_DATA(conv_data));

   // =====================================================================
   // checks and register access
   task automatic chk_reg(input string name, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (e !== g) begin
         errors++;
         $display("unexpected %s expected %h seen %h", name, e, g);
      end
   endtask

   task automatic chk_val(input string name, input logic [23:0] e, input logic [23:0] g);
      checks++;
      if (e !== g) begin
         errors++;
         $display("unexpected %s expected %h seen %h", name, e, g);
      end
   endtask

   task automatic results();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(negedge sys_clk);
      sfr_addr = a;
      sfr_wdata = v;
      sfr_wr = 1'b1;
      @(negedge sys_clk);
      sfr_wr = 1'b0;
   endtask

   // address sampled at one edge, data settled by the following fall
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(negedge sys_clk);
      sfr_addr = a;
      @(negedge sys_clk);
      v = sfr_rdata;
   endtask

   task automatic wait_flag();
      for (int i = 0; i < 3000; i++) begin
         rd(ADDR_STATUS, d);
         if (d[0] === 1'b1) return;
      end
      errors++;
      $display("unexpected done flag expected 1 seen 0");
   endtask

   function automatic logic [RES_W-1:0] val_of(input int ch);
      return vals[ch*RES_W +: RES_W];
   endfunction

   task automatic chk_slot(input int slot, input int ch);
      logic [7:0] lo_a [4] = '{ADDR_RES0_LO, ADDR_RES1_LO, ADDR_RES2_LO, ADDR_RES3_LO};
      rd(lo_a[slot], d);
      chk_reg("result low", 8'(val_of(ch)), d);
      rd(lo_a[slot] + 8'h01, d);
      chk_reg("result high", 8'(val_of(ch) >> 8), d);
   endtask

   // one single-run pass, then results, flag, interrupt and clear
   task automatic one_pass(input logic [7:0] mx, input bit man, input bit ie);
      wr(ADDR_MUX, mx);
      // trigger is dropped unless power-up is already stored
      wr(ADDR_CTRL, 8'h11);
      wr(ADDR_CTRL, 8'h31 | {1'b0, man, 3'h0, ie, 2'h0});
      wait_flag();
      repeat (2) @(negedge sys_clk);
      chk_val("irq", ie, irq);
      if (man) begin
         chk_slot(mx[5:4], mx[6:4]);
      end else begin
         for (int i = 0; i < 4; i++) chk_slot(i, {mx[6], i[1:0]});
      end
      rd(ADDR_STATUS, d);
      chk_reg("flag held", 8'h01, d);
      wr(ADDR_CTRL, 8'h19);
      rd(ADDR_STATUS, d);
      chk_reg("flag cleared", 8'h00, d);
      chk_val("irq cleared", 1'b0, irq);
   endtask

   // =====================================================================
   initial begin
      #6_000_000;
      errors++;
      results();
   end

   initial begin
      rst_b = 1'b0;
      sfr_wr = 1'b0;
      sfr_addr = 8'h00;
      sfr_wdata = 8'h00;
      dly = 4'h3;
      vals = '0;
      void'($urandom(32'h7f7848d8));
      for (int i = 0; i < 8; i++) vals[i*RES_W +: RES_W] = RES_W'($urandom());
      repeat (5) @(posedge sys_clk);
      @(negedge sys_clk);
      rst_b = 1'b1;
      rd(ADDR_CTRL, d);
      chk_reg("ctrl reset", 8'h00, d);
      rd(ADDR_DIV, d);
      chk_reg("divisor reset", 8'h14, d);
      rd(8'h90, d);
      chk_reg("unmapped", 8'h00, d);
      // random control settings reach the analog controls
      for (int k = 0; k < 6; k++) begin
         c = 8'($urandom()) & 8'h85;
         m = 8'($urandom());
         wr(ADDR_CTRL, c | 8'h28);
         wr(ADDR_MUX, m);
         wr(ADDR_CAL, ~m);
         wr(ADDR_TRIM, m ^ 8'h3C);
         wr(ADDR_STATUS, 8'hFF);
         rd(ADDR_CTRL, d);
         chk_reg("ctrl", c, d);
         rd(ADDR_CAL, d);
         chk_reg("cal", ~m & 8'h1F, d);
         rd(ADDR_STATUS, d);
         chk_reg("status ro", 8'h00, d);
         chk_val("ref sel", c[7], ref_sel);
         chk_val("ref pwr", c[0], ref_pwr);
         chk_val("order", m[7], order);
         chk_val("ibuf", m[3:0], ibuf);
         chk_val("skip", 1'(~m[4]), skip);
         chk_val("cal idx", 4'(~m[3:0]), cal_idx);
         chk_val("trim", m ^ 8'h3C, trim);
      end
      // group passes on both groups, manual passes on random channels
      one_pass(8'h03, 1'b0, 1'b1);
      dly = 4'h9;
      one_pass(8'h7F, 1'b0, 1'b0);
      for (int k = 0; k < 3; k++) one_pass(8'($urandom()) & 8'h70, 1'b1, k[0]);
      one_pass(8'h70, 1'b1, 1'b1);
      // converter clock at divisor 3 is six cycles a period
      wr(ADDR_DIV, 8'h03);
      last = 0;
      gap = 0;
      c = 8'h00;
      for (int i = 1; i < 60; i++) begin
         @(negedge sys_clk);
         if (conv_clk === 1'b1 && c[0] === 1'b0) begin
            if (last != 0) gap = i - last;
            last = i;
         end
         c[0] = conv_clk;
      end
      chk_val("conv clk period", 24'd6, 24'(gap));
      // repeat mode with a short rate word keeps launching passes
      wr(ADDR_RATE_LO, 8'h02);
      wr(ADDR_RATE_MD, 8'h00);
      wr(ADDR_RATE_HI, 8'h00);
      dly = 4'h1;
      wr(ADDR_CTRL, 8'h13);
      n = 0;
      repeat (600) begin
         @(negedge sys_clk);
         if (conv_start === 1'b1) n++;
      end
      chk_val("repeat starts", 24'd1, 24'(n >= 12));
      chk_val("conv pwr", 1'b1, cnv_pwr);
      wr(ADDR_CTRL, 8'h03);
      repeat (20) @(negedge sys_clk);
      n = 0;
      repeat (300) begin
         @(negedge sys_clk);
         if (conv_start === 1'b1) n++;
      end
      chk_val("starts when off", 24'd0, 24'(n));
      chk_val("conv pwr off", 1'b0, cnv_pwr);
      results();
   end
endmodule
`default_nettype wire
